// File: rtl/indexer_pkg.sv
// Constants, register map and carrier types of the direct-speed indexer sequencer.
// Assumes one 200 MHz clock and a cyclic link image written by software.
// Function
// RULE_01 - Indexer behaviour runs only while the control mode parameter equals 8.
// RULE_02 - Direct speed needs the method select bit on and method parameter 1_.
// RULE_03 - Both operation mode select bits on choose shortest-rotation indexing.
// RULE_04 - Speed is one 32-bit value from low and high 16-bit words.
// RULE_05 - Acceleration and deceleration always come from point table entry 1.
// RULE_06 - A start begins positioning to the next station word at commanded speed.
// RULE_07 - A start switches torque limit from stop to forward or reverse limit.
// RULE_08 - After travel completion and the set delay, torque returns to stop limit.
// RULE_09 - A start before homing raises warning 90 and is ignored.
// RULE_10 - Equal distances both ways rotate toward increasing station numbers.
// RULE_11 - Start is ignored while moving; master waits for travel completion.
// RULE_12 - Master updates station and speed words before start, allowing link delay.
// RULE_13 - In-position shows when droop lies within range at a station.
// RULE_14 - Master waits 8 ms plus link delay after mode selection before start.
// RULE_15 - Start is taken on its off-to-on edge, sampled once per link update.
package indexer_pkg;
  localparam int unsigned CLK_NS      = 5;
  localparam int unsigned MS_NS       = 1000000;
  localparam int unsigned MS_CYC      = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LINK_NS     = 1000000;
  localparam int unsigned LINK_CYC    = (LINK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  OFS_CFG     = 8'h00;
  localparam logic [7:0]  OFS_LINK    = 8'h04;
  localparam logic [7:0]  OFS_STATION = 8'h08;
  localparam logic [7:0]  OFS_SPD_LO  = 8'h0c;
  localparam logic [7:0]  OFS_SPD_HI  = 8'h10;
  localparam logic [7:0]  OFS_TQ_RUN  = 8'h14;
  localparam logic [7:0]  OFS_TQ_STOP = 8'h18;
  localparam logic [7:0]  OFS_PT1     = 8'h1c;
  localparam logic [7:0]  OFS_INPOS   = 8'h20;
  localparam logic [7:0]  OFS_STATUS  = 8'h24;
  localparam logic [7:0]  MODE_INDEX  = 8'h08;
  localparam logic [3:0]  SPEC_DIRECT = 4'h1;
  localparam logic [7:0]  WARN_HOME   = 8'h5a;
  localparam int unsigned BIT_START   = 0;
  localparam int unsigned BIT_OP1     = 1;
  localparam int unsigned BIT_OP2     = 2;
  localparam int unsigned BIT_SPEC    = 3;

  typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_HOLD} seq_e;

  typedef struct packed {
    logic spec_method_select_bit;
    logic op_mode_select_2;
    logic op_mode_select_1;
    logic start_request_bit;
  } link_bits_s;

  typedef struct packed {
    logic        go;
    logic [15:0] station;
    logic [31:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic        dir_inc;
    logic [15:0] torque;
  } motion_cmd_s;

  typedef struct packed {
    seq_e        st;
    logic [7:0]  control_mode_param;
    logic [7:0]  spec_method_param;
    link_bits_s  bits;
    logic [15:0] next_station_word;
    logic [15:0] speed_cmd_low_word;
    logic [15:0] speed_cmd_high_word;
    logic [15:0] fwd_torque_limit_param;
    logic [15:0] rev_torque_limit_param;
    logic [15:0] stop_torque_limit_param;
    logic [15:0] torque_limit_delay_param;
    logic [15:0] pt1_accel;
    logic [15:0] pt1_decel;
    logic [31:0] inpos_range;
    logic        start_prev;
    logic [31:0] link_cnt;
    logic [31:0] ms_cnt;
    logic [15:0] dly_cnt;
    logic        travel_complete_flag;
    logic        home_not_done_warning;
    logic        in_position_flag;
    motion_cmd_s cmd;
    logic        ack;
    logic [31:0] rdata;
  } state_s;
endpackage : indexer_pkg

// File: rtl/indexer_direct_speed_positioning.sv
// Indexer positioning sequencer for the direct-speed method, with Avalon-MM slave.
// Assumes motion core, homing and droop counter run on the same clock.
`timescale 1ns/1ps
module indexer_direct_speed_positioning #(
  parameter int unsigned LINK_CYCLES = indexer_pkg::LINK_CYC,
  parameter int unsigned MS_CYCLES   = indexer_pkg::MS_CYC
) (
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  input  wire logic [7:0]                address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [31:0]               writedata,
  output logic      [31:0]               readdata,
  output logic                           waitrequest,
  input  wire logic                      home_done,
  input  wire logic                      motion_done,
  input  wire logic                      at_station,
  input  wire logic [15:0]               cur_station,
  input  wire logic [15:0]               num_stations,
  input  wire logic signed [31:0]        droop_pulses,
  output indexer_pkg::motion_cmd_s       motion_cmd,
  output logic                           travel_complete_flag,
  output logic                           in_position_flag,
  output logic                           home_not_done_warning
);
  indexer_pkg::state_s q;
  indexer_pkg::state_s d;
  logic        link_tick;
  logic        ms_tick;
  logic        start_edge;
  logic        direct_on;
  logic        shortest_on;
  logic        start_ok;
  logic [16:0] dist_inc;
  logic [16:0] dist_dec;
  logic [31:0] droop_abs;

  if (LINK_CYCLES < 1 || MS_CYCLES < 1) begin : g_chk
    $error("cycle counts must be at least one");
  end

  assign readdata              = q.rdata;
  assign waitrequest           = (read | write) & ~q.ack;
  assign motion_cmd            = q.cmd;
  assign travel_complete_flag  = q.travel_complete_flag;
  assign in_position_flag      = q.in_position_flag;
  assign home_not_done_warning = q.home_not_done_warning;

  always_comb begin
    d         = q;
    d.cmd.go  = 1'b0;
    d.ack     = 1'b0;
    link_tick = (q.link_cnt == 32'(LINK_CYCLES - 1));
    ms_tick   = (q.ms_cnt == 32'(MS_CYCLES - 1));
    d.link_cnt = link_tick ? 32'h0 : q.link_cnt + 32'h1;
    d.ms_cnt   = ms_tick ? 32'h0 : q.ms_cnt + 32'h1;

    // One wait cycle per access, then a single-cycle answer
    if ((read || write) && !q.ack) begin
      d.ack   = 1'b1;
      d.rdata = 32'h0;
      if (write) begin
        if (address == indexer_pkg::OFS_CFG) begin
          d.control_mode_param = writedata[7:0];
          d.spec_method_param  = writedata[15:8];
        end else if (address == indexer_pkg::OFS_LINK) begin
          d.bits = indexer_pkg::link_bits_s'(writedata[3:0]);
        end else if (address == indexer_pkg::OFS_STATION) begin
          d.next_station_word = writedata[15:0];
        end else if (address == indexer_pkg::OFS_SPD_LO) begin
          d.speed_cmd_low_word = writedata[15:0];
        end else if (address == indexer_pkg::OFS_SPD_HI) begin
          d.speed_cmd_high_word = writedata[15:0];
        end else if (address == indexer_pkg::OFS_TQ_RUN) begin
          d.fwd_torque_limit_param = writedata[15:0];
          d.rev_torque_limit_param = writedata[31:16];
        end else if (address == indexer_pkg::OFS_TQ_STOP) begin
          d.stop_torque_limit_param  = writedata[15:0];
          d.torque_limit_delay_param = writedata[31:16];
        end else if (address == indexer_pkg::OFS_PT1) begin
          d.pt1_accel = writedata[15:0];
          d.pt1_decel = writedata[31:16];
        end else if (address == indexer_pkg::OFS_INPOS) begin
          d.inpos_range = writedata;
        end
      end else begin
        if (address == indexer_pkg::OFS_CFG) begin
          d.rdata = {16'h0, q.spec_method_param, q.control_mode_param};
        end else if (address == indexer_pkg::OFS_LINK) begin
          d.rdata = {28'h0, q.bits};
        end else if (address == indexer_pkg::OFS_STATION) begin
          d.rdata = {16'h0, q.next_station_word};
        end else if (address == indexer_pkg::OFS_SPD_LO) begin
          d.rdata = {16'h0, q.speed_cmd_low_word};
        end else if (address == indexer_pkg::OFS_SPD_HI) begin
          d.rdata = {16'h0, q.speed_cmd_high_word};
        end else if (address == indexer_pkg::OFS_TQ_RUN) begin
          d.rdata = {q.rev_torque_limit_param, q.fwd_torque_limit_param};
        end else if (address == indexer_pkg::OFS_TQ_STOP) begin
          d.rdata = {q.torque_limit_delay_param, q.stop_torque_limit_param};
        end else if (address == indexer_pkg::OFS_PT1) begin
          d.rdata = {q.pt1_decel, q.pt1_accel};
        end else if (address == indexer_pkg::OFS_INPOS) begin
          d.rdata = q.inpos_range;
        end else if (address == indexer_pkg::OFS_STATUS) begin
          d.rdata = {q.home_not_done_warning ? indexer_pkg::WARN_HOME : 8'h0,
                     q.cmd.torque, 3'h0, q.cmd.dir_inc,
                     q.home_not_done_warning, q.in_position_flag,
                     q.travel_complete_flag, q.st != indexer_pkg::ST_IDLE};
        end
      end
    end

    // RULE_15 edge per link update
    start_edge = link_tick && q.bits.start_request_bit && !q.start_prev;
    if (link_tick) begin
      d.start_prev = q.bits.start_request_bit;
    end
    // RULE_02 direct speed enable
    direct_on   = q.bits.spec_method_select_bit &&
                  (q.spec_method_param[7:4] == indexer_pkg::SPEC_DIRECT);
    // RULE_03 shortest rotation select
    shortest_on = q.bits.op_mode_select_1 && q.bits.op_mode_select_2;
    // RULE_01 indexer mode gate
    start_ok    = start_edge && direct_on && shortest_on &&
                  (q.control_mode_param == indexer_pkg::MODE_INDEX);

    // RULE_10 tie goes increasing
    dist_inc = (q.next_station_word >= cur_station) ?
               {1'b0, q.next_station_word - cur_station} :
               {1'b0, q.next_station_word} + {1'b0, num_stations} - {1'b0, cur_station};
    dist_dec = (dist_inc == 17'h0) ? 17'h0 : {1'b0, num_stations} - dist_inc;

    // RULE_09 warning clears once homing is done
    d.home_not_done_warning = q.home_not_done_warning && !home_done;

    case (q.st)
      indexer_pkg::ST_IDLE, indexer_pkg::ST_HOLD: begin
        if (q.st == indexer_pkg::ST_HOLD) begin
          if (ms_tick) begin
            d.dly_cnt = q.dly_cnt + 16'h1;
          end
          // RULE_08 back to stop limit
          if (q.dly_cnt >= q.torque_limit_delay_param) begin
            d.st         = indexer_pkg::ST_IDLE;
            d.cmd.torque = q.stop_torque_limit_param;
          end
        end else begin
          d.cmd.torque = q.stop_torque_limit_param;
        end
        if (start_ok && !home_done) begin
          // RULE_09 ignore start, warn
          d.home_not_done_warning = 1'b1;
        end else if (start_ok) begin
          // RULE_06 launch toward station
          d.st                   = indexer_pkg::ST_MOVE;
          d.travel_complete_flag = 1'b0;
          d.cmd.go               = 1'b1;
          d.cmd.station          = q.next_station_word;
          // RULE_04 assemble 32-bit speed
          d.cmd.speed            = {q.speed_cmd_high_word, q.speed_cmd_low_word};
          // RULE_05 point table 1 ramps
          d.cmd.accel            = q.pt1_accel;
          d.cmd.decel            = q.pt1_decel;
          d.cmd.dir_inc          = (dist_inc <= dist_dec);
          // RULE_07 running torque limit
          d.cmd.torque           = (dist_inc <= dist_dec) ? q.fwd_torque_limit_param :
                                                           q.rev_torque_limit_param;
        end
      end
      indexer_pkg::ST_MOVE: begin
        // RULE_11 starts ignored while moving
        if (motion_done) begin
          d.st                   = indexer_pkg::ST_HOLD;
          d.travel_complete_flag = 1'b1;
          d.dly_cnt              = 16'h0;
          d.ms_cnt               = 32'h0;
        end
      end
      default: begin
        d.st = indexer_pkg::ST_IDLE;
      end
    endcase

    // RULE_13 droop within range at a station
    droop_abs = droop_pulses[31] ? 32'(-droop_pulses) : droop_pulses;
    d.in_position_flag = at_station && (droop_abs <= q.inpos_range) &&
                         (q.control_mode_param == indexer_pkg::MODE_INDEX);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_mode;
    q.cmd.go |-> $past(q.control_mode_param) == indexer_pkg::MODE_INDEX;
  endproperty
  a_mode: assert property (p_mode) else $error("move outside indexer mode"); // RULE_01

  property p_spec;
    q.cmd.go |-> $past(q.bits.spec_method_select_bit) &&
                 $past(q.spec_method_param[7:4]) == indexer_pkg::SPEC_DIRECT;
  endproperty
  a_spec: assert property (p_spec) else $error("move without direct speed"); // RULE_02

  property p_opsel;
    q.cmd.go |-> $past(q.bits.op_mode_select_1) && $past(q.bits.op_mode_select_2);
  endproperty
  a_opsel: assert property (p_opsel) else $error("move without shortest mode"); // RULE_03

  property p_speed;
    q.cmd.go |-> q.cmd.speed == {$past(q.speed_cmd_high_word), $past(q.speed_cmd_low_word)};
  endproperty
  a_speed: assert property (p_speed) else $error("speed words misassembled"); // RULE_04

  property p_ramp;
    q.cmd.go |-> q.cmd.accel == $past(q.pt1_accel) && q.cmd.decel == $past(q.pt1_decel);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramps not from entry 1"); // RULE_05

  property p_station;
    q.cmd.go |-> q.st == indexer_pkg::ST_MOVE && q.cmd.station == $past(q.next_station_word)
                 ##1 !q.cmd.go;
  endproperty
  a_station: assert property (p_station) else $error("wrong target or go width"); // RULE_06

  property p_tq_run;
    q.cmd.go |-> q.cmd.torque == (q.cmd.dir_inc ? $past(q.fwd_torque_limit_param)
                                                : $past(q.rev_torque_limit_param));
  endproperty
  a_tq_run: assert property (p_tq_run) else $error("running torque limit wrong"); // RULE_07

  property p_tq_stop;
    (q.st == indexer_pkg::ST_HOLD) ##1 (q.st == indexer_pkg::ST_IDLE) |->
      q.cmd.torque == q.stop_torque_limit_param && $past(q.dly_cnt) >=
      $past(q.torque_limit_delay_param);
  endproperty
  a_tq_stop: assert property (p_tq_stop) else $error("stop limit not restored"); // RULE_08

  property p_warn;
    $rose(q.home_not_done_warning) |-> !q.cmd.go && q.st == $past(q.st);
  endproperty
  a_warn: assert property (p_warn) else $error("start not ignored before homing"); // RULE_09

  property p_busy;
    q.st == indexer_pkg::ST_MOVE && !motion_done |=> q.st == indexer_pkg::ST_MOVE && !q.cmd.go;
  endproperty
  a_busy: assert property (p_busy) else $error("start taken while moving"); // RULE_11

  property p_edge;
    q.cmd.go |-> $past(link_tick) && !$past(q.start_prev);
  endproperty
  a_edge: assert property (p_edge) else $error("start not a sampled edge"); // RULE_15

  property p_dir;
    q.cmd.go && $past(dist_inc) == $past(dist_dec) |-> q.cmd.dir_inc;
  endproperty
  a_dir: assert property (p_dir) else $error("tie did not go increasing"); // RULE_10

  property p_go_idle;
    q.cmd.go |-> $past(q.st) != indexer_pkg::ST_MOVE;
  endproperty
  a_go_idle: assert property (p_go_idle) else $error("move launched while moving"); // RULE_11

  property p_go_clr;
    q.cmd.go |-> !q.travel_complete_flag;
  endproperty
  a_go_clr: assert property (p_go_clr) else $error("completion left on at start"); // RULE_06

  property p_tc_set;
    q.st == indexer_pkg::ST_MOVE && motion_done |=>
      q.travel_complete_flag && q.st == indexer_pkg::ST_HOLD;
  endproperty
  a_tc_set: assert property (p_tc_set) else $error("completion not reported"); // RULE_08

  property p_hold_tq;
    q.st == indexer_pkg::ST_HOLD && q.dly_cnt < q.torque_limit_delay_param && !start_ok |=>
      $stable(q.cmd.torque);
  endproperty
  a_hold_tq: assert property (p_hold_tq) else $error("torque left run limit early"); // RULE_08

  property p_idle_tq;
    q.st == indexer_pkg::ST_IDLE && !start_ok |=>
      q.cmd.torque == $past(q.stop_torque_limit_param);
  endproperty
  a_idle_tq: assert property (p_idle_tq) else $error("idle torque not stop limit"); // RULE_08

  property p_warn_clr;
    q.home_not_done_warning && home_done |=> !q.home_not_done_warning;
  endproperty
  a_warn_clr: assert property (p_warn_clr) else $error("warning kept after homing"); // RULE_09

  property p_inpos;
    q.in_position_flag |-> $past(at_station) &&
                           $past(q.control_mode_param) == indexer_pkg::MODE_INDEX;
  endproperty
  a_inpos: assert property (p_inpos) else $error("in position off station"); // RULE_13

  property p_inpos_set;
    at_station && q.control_mode_param == indexer_pkg::MODE_INDEX && !droop_pulses[31] &&
      $unsigned(droop_pulses) <= q.inpos_range |=> q.in_position_flag;
  endproperty
  a_inpos_set: assert property (p_inpos_set) else $error("in position not shown"); // RULE_13
endmodule : indexer_direct_speed_positioning

// File: dv/motion_core_model.sv
// Behavioural motion core that answers the sequencer's move commands.
// Assumes the sequencer clock and reset; latency sets a prompt or a slow answer.
`timescale 1ns/1ps
module motion_core_model (
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  input  wire logic [15:0]              latency,
  input  wire indexer_pkg::motion_cmd_s motion_cmd,
  output logic                          motion_done,
  output logic                          at_station,
  output logic [15:0]                   cur_station,
  output logic signed [31:0]            droop_pulses
);
  logic [15:0] left_q;
  logic [15:0] target_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      left_q      <= 16'h0;
      target_q    <= 16'h0;
      motion_done <= 1'b0;
      at_station  <= 1'b1;
      cur_station <= 16'h0;
    end else begin
      motion_done <= 1'b0;
      if (motion_cmd.go) begin
        left_q     <= latency;
        target_q   <= motion_cmd.station;
        at_station <= 1'b0;
      end else if (left_q == 16'h1) begin
        left_q      <= 16'h0;
        motion_done <= 1'b1;
        at_station  <= 1'b1;
        cur_station <= target_q;
      end else if (left_q != 16'h0) begin
        left_q <= left_q - 16'h1;
      end
    end
  end
  // Error settles to a few pulses only when parked on a station
  assign droop_pulses = at_station ? 32'sh2 : 32'sh1388;
endmodule : motion_core_model

// File: dv/test_indexer_direct_speed_positioning.sv
// Self-checking bench for the indexer sequencer, driven over Avalon-MM.
// Assumes short link and ms periods set through the design's parameters.
`timescale 1ns/1ps
module test_indexer_direct_speed_positioning;
  localparam int          LINK = 4;
  localparam int          MSC  = 8;
  localparam logic [15:0] NST  = 16'h0008;
  localparam logic [15:0] FWD  = 16'h0123;
  localparam logic [15:0] REV  = 16'h0456;
  localparam logic [15:0] STP  = 16'h0077;
  localparam logic [15:0] ACC  = 16'h0010;
  localparam logic [15:0] DEC  = 16'h0020;
  logic                       clock = 1'b0;
  logic                       sys_rst = 1'b1;
  logic                       read = 1'b0;
  logic                       write = 1'b0;
  logic                       home_done = 1'b0;
  logic [7:0]                 address = 8'h00;
  logic [31:0]                writedata = 32'h0;
  logic [31:0]                readdata;
  logic [31:0]                rdv;
  logic                       waitrequest;
  logic                       motion_done;
  logic                       at_station;
  logic                       travel_complete_flag;
  logic                       in_position_flag;
  logic                       home_not_done_warning;
  logic [15:0]                cur_station;
  logic [15:0]                latency = 16'h0004;
  logic [15:0]                lfsr_q = 16'h9941;
  logic signed [31:0]         droop_pulses;
  indexer_pkg::motion_cmd_s   motion_cmd;
  indexer_pkg::motion_cmd_s   exp_cmd;
  indexer_pkg::motion_cmd_s   exp_q[$];
  int                         num_errors = 0;
  int                         checks = 0;
  int                         cyc = 0;
  int                         gos = 0;
  logic [31:0] cfgs[4] = '{32'h1007, 32'h0008, 32'h1008, 32'h1008};
  logic [3:0]  lnks[4] = '{4'hf, 4'hf, 4'h7, 4'hb};

  always #2.5 clock = ~clock;

  indexer_direct_speed_positioning #(.LINK_CYCLES(LINK), .MS_CYCLES(MSC)) dut (
    .clock(clock), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .home_done(home_done), .motion_done(motion_done), .at_station(at_station),
    .cur_station(cur_station), .num_stations(NST), .droop_pulses(droop_pulses),
    .motion_cmd(motion_cmd), .travel_complete_flag(travel_complete_flag),
    .in_position_flag(in_position_flag), .home_not_done_warning(home_not_done_warning));

  motion_core_model far (
    .clock(clock), .sys_rst(sys_rst), .latency(latency), .motion_cmd(motion_cmd),
    .motion_done(motion_done), .at_station(at_station), .cur_station(cur_station),
    .droop_pulses(droop_pulses));

  task automatic summarize;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    chk(n < 50, "bus hang");
    rdv = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    // Settle point for checks that follow an access
    @(negedge clock);
  endtask : bus

  task automatic start_move(input logic [15:0] st, input logic [31:0] sp,
                            input logic [3:0] lk, input bit ok);
    indexer_pkg::motion_cmd_s e;
    int g;
    int up;
    int dn;
    up = (st + NST - cur_station) % NST;
    dn = (cur_station + NST - st) % NST;
    e = '{1'b1, st, sp, ACC, DEC, (up <= dn), (up <= dn) ? FWD : REV};
    bus(1'b1, 8'h08, {16'h0, st});
    bus(1'b1, 8'h0c, {16'h0, sp[15:0]});
    bus(1'b1, 8'h10, {16'h0, sp[31:16]});
    bus(1'b1, 8'h04, {28'h0, lk & 4'he});
    repeat (8 * MSC + LINK) @(posedge clock);
    if (ok) begin
      exp_q.push_back(e);
      exp_cmd = e;
    end
    g = gos;
    bus(1'b1, 8'h04, {28'h0, lk});
    for (int n = 0; n < 3 * LINK && !(ok && gos != g); n++) @(negedge clock);
    chk(ok == (gos != g), "start outcome");
  endtask : start_move

  task automatic wait_done;
    int n;
    n = 0;
    while (travel_complete_flag !== 1'b1 && n < 500) begin
      @(negedge clock);
      n++;
    end
    chk(n < 500, "no completion");
    repeat (2 * MSC - 4) @(negedge clock);
    chk(motion_cmd.torque === exp_cmd.torque, "run torque held");
    repeat (8) @(negedge clock);
    chk(motion_cmd.torque === STP, "stop torque restored");
  endtask : wait_done

  // Every move command against the expected queue
  always @(negedge clock) begin
    if (!sys_rst && motion_cmd.go === 1'b1) begin
      gos++;
      if (exp_q.size() == 0) chk(1'b0, "unexpected move start");
      else chk(motion_cmd === exp_q.pop_front(), "move command");
    end
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    bus(1'b1, 8'h18, {16'h2, STP});
    chk(motion_cmd.torque === STP, "idle torque");
    bus(1'b1, 8'h14, {REV, FWD});
    bus(1'b1, 8'h1c, {DEC, ACC});
    bus(1'b1, 8'h20, 32'h3);
    bus(1'b0, 8'h14, 32'h0);
    chk(rdv === {REV, FWD}, "torque limit readback");
    bus(1'b0, 8'h30, 32'h0);
    chk(rdv === 32'h0, "unmapped read");
    bus(1'b1, 8'h00, 32'h1008);
    bus(1'b1, 8'h04, 32'he);
    repeat (8 * MSC) @(posedge clock);
    start_move(16'h3, 32'h100, 4'hf, 1'b0);
    bus(1'b0, 8'h24, 32'h0);
    chk(home_not_done_warning === 1'b1 && rdv[31:24] === 8'h5a, "warning");
    @(posedge clock) home_done <= 1'b1;
    repeat (3) @(negedge clock);
    chk(home_not_done_warning === 1'b0, "warning clear");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h00, cfgs[i]);
      start_move(16'h2, 32'h200, lnks[i], 1'b0);
      chk(in_position_flag === (i != 0), "in position vs mode");
    end
    bus(1'b1, 8'h00, 32'h1008);
    bus(1'b1, 8'h20, 32'h1);
    chk(in_position_flag === 1'b0, "droop outside range");
    bus(1'b1, 8'h20, 32'h3);
    start_move(16'h4, 32'h12345678, 4'hf, 1'b1);
    wait_done();
    start_move(16'h1, 32'h0, 4'hf, 1'b1);
    wait_done();
    start_move(16'h6, 32'hffffffff, 4'hf, 1'b1);
    wait_done();
    for (int i = 0; i < 3; i++) begin
      lfsr_q = lfsr(lfsr_q);
      rdv[15:0] = lfsr_q;
      lfsr_q = lfsr(lfsr_q);
      start_move({13'h0, lfsr_q[2:0]}, {rdv[15:0], lfsr_q}, 4'hf, 1'b1);
      wait_done();
    end
    latency = 16'h00c8;
    start_move(16'h2, 32'h300, 4'hf, 1'b1);
    start_move(16'h5, 32'h400, 4'hf, 1'b0);
    chk(travel_complete_flag === 1'b0, "busy while moving");
    chk(in_position_flag === 1'b0, "not in position while moving");
    wait_done();
    chk(in_position_flag === 1'b1, "in position after move");
    summarize();
  end
endmodule : test_indexer_direct_speed_positioning
